// file: common/tpf_pkg.sv
// shared constants for the three-port queue control block
// assumes nothing beyond a synthesizable systemverilog tool flow
package tpf_pkg;
	localparam int PORT_A_WIDTH  = 36;
	localparam int PORT_BC_WIDTH = 18;
	localparam int QUEUE_DEPTH   = 16;
	// sampled input vector layout, low bit first
	localparam int SAMP_CLK_A    = 0;
	localparam int SAMP_CLK_B    = 1;
	localparam int SAMP_CLK_C    = 2;
	localparam int SAMP_SEL_A    = 3;
	localparam int SAMP_EN_A     = 4;
	localparam int SAMP_DIR_A    = 5;
	localparam int SAMP_SEL_B    = 6;
	localparam int SAMP_RD_B     = 7;
	localparam int SAMP_WR_C     = 8;
	localparam int SAMP_MODE     = 9;
	localparam int SAMP_DATA_A   = 10;
	localparam int SAMP_DATA_C   = SAMP_DATA_A + PORT_A_WIDTH;
	localparam int SAMP_WIDTH    = SAMP_DATA_C + PORT_BC_WIDTH;
	// selects and mode idle high, everything else low
	localparam logic [SAMP_WIDTH-1:0] SAMP_RESET =
		SAMP_WIDTH'((64'h1 << SAMP_SEL_A) | (64'h1 << SAMP_SEL_B) | (64'h1 << SAMP_MODE));
endpackage

// file: test/tpf_port_control_assertions.sv
// pin-level assertions for the three-port queue control block
// assumes bind onto tpf_port_control; port clocks have phases of several clk
`timescale 1ns/1ps
module tpf_port_control_assertions (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic portAClock,
	input wire logic portASelect_n,
	input wire logic portATransferEnable,
	input wire logic portAWrite,
	input wire logic portADataOe_n,
	input wire logic portAEmptyOrOutReady,
	input wire logic portAFullOrInReady,
	input wire logic portBClock,
	input wire logic portBSelect_n,
	input wire logic portBReadEnable,
	input wire logic portBDataOe_n,
	input wire logic portBEmptyOrOutReady,
	input wire logic portCClock,
	input wire logic portCWriteEnable,
	input wire logic portCFullOrInReady
);
	logic [7:0] sinceA_q, sinceB_q, sinceC_q, wrAge_q, rdAge_q, wcAge_q;
	function automatic logic [7:0] bump(logic [7:0] v);
		return (&v) ? v : v + 8'h01;
	endfunction
	// ages saturate so long idle spans never wrap into a false match
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{sinceA_q, sinceB_q, sinceC_q} <= '0;
			{wrAge_q, rdAge_q, wcAge_q} <= '1;
		end else begin
			sinceA_q <= portAClock ? 8'h00 : bump(sinceA_q);
			sinceB_q <= portBClock ? 8'h00 : bump(sinceB_q);
			sinceC_q <= portCClock ? 8'h00 : bump(sinceC_q);
			wrAge_q  <= (!portASelect_n && portATransferEnable && portAWrite) ? 8'h00 : bump(wrAge_q);
			rdAge_q  <= (!portBSelect_n && portBReadEnable) ? 8'h00 : bump(rdAge_q);
			wcAge_q  <= portCWriteEnable ? 8'h00 : bump(wcAge_q);
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence sSelAOff; portASelect_n [*3]; endsequence
	sequence sReadAOn; (!portASelect_n && !portAWrite) [*3]; endsequence
	sequence sSelBOff; portBSelect_n [*3]; endsequence
	sequence sSelBOn; !portBSelect_n [*3]; endsequence
	AST_A_FLOAT: assert property (sSelAOff |-> portADataOe_n)
		else $error("port a driven while off");
	AST_A_DRIVE: assert property (sReadAOn |-> !portADataOe_n)
		else $error("a read undriven");
	AST_B_FLOAT: assert property (sSelBOff |-> portBDataOe_n)
		else $error("port b driven while off");
	AST_B_DRIVE: assert property (sSelBOn |-> !portBDataOe_n)
		else $error("port b read undriven");
	AST_A_FLAG_EDGE: assert property (($changed(portAEmptyOrOutReady) || $changed(portAFullOrInReady))
		|-> sinceA_q <= 8'h02) else $error("port a flag off its edge");
	AST_B_FLAG_EDGE: assert property ($changed(portBEmptyOrOutReady) |-> sinceB_q <= 8'h02)
		else $error("b flag off edge");
	AST_C_FLAG_EDGE: assert property ($changed(portCFullOrInReady) |-> sinceC_q <= 8'h02)
		else $error("c flag off edge");
	AST_A_FULL_CAUSE: assert property ($fell(portAFullOrInReady) |-> wrAge_q <= 8'h18)
		else $error("a full no write");
	AST_B_EMPTY_CAUSE: assert property ($fell(portBEmptyOrOutReady) |-> rdAge_q <= 8'h1c)
		else $error("b empty no read");
	AST_C_FULL_CAUSE: assert property ($fell(portCFullOrInReady) |-> wcAge_q <= 8'h20)
		else $error("c full no write");
endmodule
bind tpf_port_control tpf_port_control_assertions i_tpf_port_control_assertions (.*);

// file: test/tpf_port_control_tb.sv
// self-checking bench for the three-port queue control block
// assumes tpf_port_partner makes the port clocks from clk
`timescale 1ns/1ps
module tpf_port_control_tb;
	import tpf_pkg::*;
	localparam int D = 4;
	logic clk, arst_n, portAClock, portBClock, portCClock, endianTimingSelect;
	logic portASelect_n, portATransferEnable, portAWrite, portADataOe_n, portAEmptyOrOutReady;
	logic portAFullOrInReady, portBSelect_n, portBReadEnable, portBDataOe_n, portBEmptyOrOutReady;
	logic portCWriteEnable, portCFullOrInReady;
	logic [PORT_A_WIDTH-1:0]  portADataIn, portADataOut;
	logic [PORT_BC_WIDTH-1:0] portBData, portCData;
	int failCount, numChecks;
	tpf_port_control #(.DEPTH(D)) i_tpf_port_control (.*);
	tpf_port_partner i_tpf_port_partner (.*);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [35:0] seen, logic [35:0] exp);
		numChecks++;
		if (seen !== exp) begin
			failCount++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic doReset(logic m);
		arst_n <= 1'b0;
		endianTimingSelect <= m;
		repeat (3) @(posedge clk);
		chk("oe", {portADataOe_n, portBDataOe_n}, 36'h3);
		arst_n <= 1'b1;
		repeat (40) @(posedge clk);
	endtask
	// each transfer holds its qualifiers over one whole port clock period
	task automatic opA(logic wr, logic en, logic [35:0] d);
		@(negedge portAClock);
		portASelect_n <= 1'b0;
		portATransferEnable <= en;
		portAWrite <= wr;
		portADataIn <= d;
		repeat (4) @(posedge clk);
		chk("a_oe", portADataOe_n, wr);
		@(negedge portAClock);
		portASelect_n <= 1'b1;
		portATransferEnable <= 1'b0;
	endtask
	// enable and read direction raised while the select stays high
	task automatic opAUnselected();
		@(negedge portAClock);
		portATransferEnable <= 1'b1;
		portAWrite <= 1'b0;
		repeat (4) @(posedge clk);
		chk("a_unsel_oe", portADataOe_n, 1);
		@(negedge portAClock);
		portATransferEnable <= 1'b0;
	endtask
	task automatic opB(logic select_n, logic en);
		@(negedge portBClock);
		portBSelect_n <= select_n;
		portBReadEnable <= en;
		@(negedge portBClock);
		portBSelect_n <= 1'b1;
		portBReadEnable <= 1'b0;
	endtask
	task automatic opC(logic [17:0] d);
		@(negedge portCClock);
		portCWriteEnable <= 1'b1;
		portCData <= d;
		@(negedge portCClock);
		portCWriteEnable <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic testStdCtoA();
		chk("a_ef", portAEmptyOrOutReady, 0);
		chk("c_ff", portCFullOrInReady, 1);
		opC(18'h2a5c3);
		opC(18'h01d7e);
		repeat (60) @(posedge clk);
		chk("a_ef", portAEmptyOrOutReady, 1);
		chk("a_nofall", portADataOut, 0);
		opA(0, 0, 0);
		chk("a_off", portADataOut, 0);
		opAUnselected();
		chk("a_unsel", portADataOut, 0);
		opA(0, 1, 0);
		chk("a_rd", portADataOut, 36'h00002a5c3);
		opA(0, 1, 0);
		chk("a_rd", portADataOut, 36'h000001d7e);
		repeat (25) @(posedge clk);
		chk("a_ef", portAEmptyOrOutReady, 0);
	endtask
	// far side stalls while port a overfills the queue, then drains it
	task automatic testStdAtoB();
		int k;
		chk("a_ff", portAFullOrInReady, 1);
		for (int i = 0; i < 12; i++) opA(1, 1, {18'h3ffff, 18'h00100 + 18'(i)});
		repeat (30) @(posedge clk);
		chk("a_ff", portAFullOrInReady, 0);
		chk("b_ef", {portBEmptyOrOutReady, portBDataOe_n}, 36'h3);
		opB(1'b0, 1'b0);
		chk("b_off", portBData, 0);
		opB(1'b1, 1'b1);
		chk("b_unsel", portBData, 0);
		for (k = 0; k < 12 && portBEmptyOrOutReady === 1'b1; k++) begin
			opB(1'b0, 1'b1);
			chk("b_rd", portBData, 18'h00100 + 18'(k));
			repeat (14) @(posedge clk);
		end
		repeat (30) @(posedge clk);
		// the two prefetch slots hold words beyond the memory depth
		chk("b_cnt", k, D + 2);
		chk("b_ef", portBEmptyOrOutReady, 0);
		chk("a_ff", portAFullOrInReady, 1);
	endtask
	task automatic testFwft();
		doReset(1'b0);
		chk("rdy", {portAEmptyOrOutReady, portAFullOrInReady, portCFullOrInReady}, 36'h3);
		opC(18'h1b00d);
		repeat (60) @(posedge clk);
		chk("a_or", portAEmptyOrOutReady, 1);
		chk("a_fall", portADataOut, 36'h00001b00d);
		opA(0, 1, 0);
		repeat (25) @(posedge clk);
		chk("a_or", portAEmptyOrOutReady, 0);
		opA(1, 1, 36'h000012345);
		repeat (60) @(posedge clk);
		chk("b_or", portBEmptyOrOutReady, 1);
		chk("b_fall", portBData, 18'h12345);
		for (int i = 0; i < 12; i++) opC(18'(i));
		repeat (30) @(posedge clk);
		chk("c_ir", portCFullOrInReady, 0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{arst_n, portATransferEnable, portAWrite, portBReadEnable, portCWriteEnable} = '0;
		{endianTimingSelect, portASelect_n, portBSelect_n} = '1;
		portADataIn = '0;
		portCData = '0;
		failCount = 0;
		numChecks = 0;
		doReset(1'b1);
		testStdCtoA();
		testStdAtoB();
		testFwft();
		summarize();
	end
	// the whole run needs about 1400 clk; this leaves ample margin
	initial begin
		#100us;
		failCount++;
		summarize();
	end
endmodule

// file: test/tpf_port_partner.sv
// far-side model: free-running clocks of the three attached buses
// assumes clk is the system clock and arst_n the raw reset
`timescale 1ns/1ps
module tpf_port_partner (
	input  wire logic clk,
	input  wire logic arst_n,
	output logic      portAClock,
	output logic      portBClock,
	output logic      portCClock
);
	logic [3:0] warm_q, a_q, b_q, c_q;
	// unequal periods keep the ports out of step; every phase lasts 5 clk or more
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{warm_q, a_q, b_q, c_q} <= '0;
		end else if (warm_q != 4'hf) begin
			warm_q <= warm_q + 4'h1;
		end else begin
			a_q <= (a_q == 4'h9) ? 4'h0 : a_q + 4'h1;
			b_q <= (b_q == 4'hb) ? 4'h0 : b_q + 4'h1;
			c_q <= (c_q == 4'hd) ? 4'h0 : c_q + 4'h1;
		end
	end
	assign portAClock = (a_q >= 4'h5);
	assign portBClock = (b_q >= 4'h6);
	assign portCClock = (c_q >= 4'h7);
endmodule

// file: verilog/tpf_port_control.sv
// three-port queue control: port a (36-bit, both ways), port b (18-bit out), port c (18-bit in)
// assumes port clocks and pins arrive from outside and run well below clk/4
// Notes on behaviour
// - port a moves data only while select low
// - port a data floats while select high
// - port b reads only while select low
// - port b data floats while select high
// - port a moves data only while enable high
// - standard mode: port a flag shows empty
// - fall-through mode: port a flag shows ready
// - standard mode: port b flag shows empty
// - fall-through mode: port b flag shows ready
// - standard mode: port a flag shows full
// - fall-through mode: port a shows space
// - standard mode: port c flag shows full
// - fall-through mode: port c shows space
// - port a flags change on port a edges
// - port b flags change on port b edges
// - port c flags change on port c edges
// - each port clock times its own transfers
// - timing select high standard, low fall-through
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module tpf_pair_buffer #(
	parameter int WIDTH = 18
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	logic [WIDTH-1:0] slot0_q;
	logic [WIDTH-1:0] slot1_q;
	logic [1:0]       count_q;
	logic             push;
	logic             pop;

	assign inReady  = (count_q != 2'h2);
	assign outValid = (count_q != 2'h0);
	assign outData  = slot0_q;
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= 2'h0;
		end else begin
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slot0_q <= '0;
			slot1_q <= '0;
		end else begin
			if (pop) begin
				slot0_q <= (count_q == 2'h2) ? slot1_q : inData;
			end else if (push && count_q == 2'h0) begin
				slot0_q <= inData;
			end
			if (push && (count_q == 2'h2 || (count_q == 2'h1 && !pop))) begin
				slot1_q <= inData;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module tpf_lane #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             fallThrough,
	input  wire logic             pushEn,
	input  wire logic [WIDTH-1:0] pushData,
	input  wire logic             readStrobe,
	output logic      [WIDTH-1:0] outData,
	output logic                  outReady,
	output logic                  empty,
	output logic                  full
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr_q;
	logic [AW:0]      rdPtr_q;
	logic             memEmpty;
	logic             bufInReady;
	logic             bufValid;
	logic             bufTake;
	logic [WIDTH-1:0] bufData;
	logic             memPop;
	logic             loadOut;

	assign memEmpty = (wrPtr_q == rdPtr_q);
	assign full     = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && (wrPtr_q[AW] != rdPtr_q[AW]);
	assign memPop   = !memEmpty && bufInReady;
	assign empty    = memEmpty && !bufValid;

	always_ff @(posedge clk) begin
		if (pushEn && !full) begin
			mem[wrPtr_q[AW-1:0]] <= pushData;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (pushEn && !full) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (memPop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
		end
	end

	// the pair buffer prefetches so a stalled reader never drops a popped word
	tpf_pair_buffer #(.WIDTH(WIDTH)) prefetch (
		.clk      (clk),
		.rst_n    (rst_n),
		.inValid  (!memEmpty),
		.inReady  (bufInReady),
		.inData   (mem[rdPtr_q[AW-1:0]]),
		.outValid (bufValid),
		.outReady (bufTake),
		.outData  (bufData)
	);

	// fall-through refills the output without a read; standard loads only on a read
	assign loadOut = bufValid && (fallThrough ? (!outReady || readStrobe) : readStrobe);
	assign bufTake = loadOut;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			outData  <= '0;
			outReady <= 1'b0;
		end else begin
			if (loadOut) begin
				outData <= bufData;
			end
			if (loadOut) begin
				outReady <= 1'b1;
			end else if (readStrobe || !fallThrough) begin
				outReady <= 1'b0;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module tpf_port_control
	import tpf_pkg::*;
#(
	parameter int DEPTH = tpf_pkg::QUEUE_DEPTH
) (
	input  wire logic                              clk,
	input  wire logic                              arst_n,
	input  wire logic                              portAClock,
	input  wire logic                              portASelect_n,
	input  wire logic                              portATransferEnable,
	input  wire logic                              portAWrite,
	input  wire logic [tpf_pkg::PORT_A_WIDTH-1:0]  portADataIn,
	output logic      [tpf_pkg::PORT_A_WIDTH-1:0]  portADataOut,
	output logic                                   portADataOe_n,
	output logic                                   portAEmptyOrOutReady,
	output logic                                   portAFullOrInReady,
	input  wire logic                              portBClock,
	input  wire logic                              portBSelect_n,
	input  wire logic                              portBReadEnable,
	output logic      [tpf_pkg::PORT_BC_WIDTH-1:0] portBData,
	output logic                                   portBDataOe_n,
	output logic                                   portBEmptyOrOutReady,
	input  wire logic                              portCClock,
	input  wire logic                              portCWriteEnable,
	input  wire logic [tpf_pkg::PORT_BC_WIDTH-1:0] portCData,
	output logic                                   portCFullOrInReady,
	input  wire logic                              endianTimingSelect
);
	import tpf_pkg::*;

	logic [1:0]            rstSync_q;
	logic                  rst_n;
	logic [SAMP_WIDTH-1:0] samp1_q;
	logic [SAMP_WIDTH-1:0] samp2_q;
	logic [2:0]            clkPrev_q;
	logic                  aEdge;
	logic                  bEdge;
	logic                  cEdge;
	logic [1:0]            modeWait_q;
	logic                  modeValid_q;
	logic                  fallThrough_q;
	logic                  aXfer;
	logic                  aWrite;
	logic                  aRead;
	logic                  bRead;
	logic                  cWrite;
	logic [PORT_BC_WIDTH-1:0] abOut;
	logic                  abReady;
	logic                  abEmpty;
	logic                  abFull;
	logic [PORT_BC_WIDTH-1:0] caOut;
	logic                  caReady;
	logic                  caEmpty;
	logic                  caFull;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rst_n = rstSync_q[1];

	// port clocks are sampled like any pin, so data and clock stay aligned
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			samp1_q <= SAMP_RESET;
			samp2_q <= SAMP_RESET;
		end else begin
			samp1_q <= {portCData, portADataIn, endianTimingSelect, portCWriteEnable, portBReadEnable,
				portBSelect_n, portAWrite, portATransferEnable, portASelect_n,
				portCClock, portBClock, portAClock};
			samp2_q <= samp1_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clkPrev_q <= 3'h0;
		end else begin
			clkPrev_q <= samp2_q[SAMP_CLK_C:SAMP_CLK_A];
		end
	end
	assign aEdge = samp2_q[SAMP_CLK_A] && !clkPrev_q[0];
	assign bEdge = samp2_q[SAMP_CLK_B] && !clkPrev_q[1];
	assign cEdge = samp2_q[SAMP_CLK_C] && !clkPrev_q[2];

	// timing mode is caught once and then held
	// wait out the two sampler stages, which still hold their reset pattern
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			modeWait_q    <= 2'h0;
			modeValid_q   <= 1'b0;
			fallThrough_q <= 1'b0;
		end else if (!modeValid_q) begin
			if (modeWait_q == 2'h2) begin
				modeValid_q   <= 1'b1;
				fallThrough_q <= !samp2_q[SAMP_MODE];
			end else begin
				modeWait_q <= modeWait_q + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign aXfer  = aEdge && modeValid_q && !samp2_q[SAMP_SEL_A] && samp2_q[SAMP_EN_A];
	assign aWrite = aXfer && samp2_q[SAMP_DIR_A];
	assign aRead  = aXfer && !samp2_q[SAMP_DIR_A];
	assign bRead  = bEdge && modeValid_q && !samp2_q[SAMP_SEL_B] && samp2_q[SAMP_RD_B];
	assign cWrite = cEdge && modeValid_q && samp2_q[SAMP_WR_C];

	// port a feeds the low half of its word toward port b; no bus sizing here
	tpf_lane #(.WIDTH(PORT_BC_WIDTH), .DEPTH(DEPTH)) aToBQueue (
		.clk         (clk),
		.rst_n       (rst_n),
		.fallThrough (fallThrough_q),
		.pushEn      (aWrite),
		.pushData    (samp2_q[SAMP_DATA_A +: PORT_BC_WIDTH]),
		.readStrobe  (bRead),
		.outData     (abOut),
		.outReady    (abReady),
		.empty       (abEmpty),
		.full        (abFull)
	);

	tpf_lane #(.WIDTH(PORT_BC_WIDTH), .DEPTH(DEPTH)) cToAQueue (
		.clk         (clk),
		.rst_n       (rst_n),
		.fallThrough (fallThrough_q),
		.pushEn      (cWrite),
		.pushData    (samp2_q[SAMP_DATA_C +: PORT_BC_WIDTH]),
		.readStrobe  (aRead),
		.outData     (caOut),
		.outReady    (caReady),
		.empty       (caEmpty),
		.full        (caFull)
	);

	assign portADataOut = {{(PORT_A_WIDTH-PORT_BC_WIDTH){1'b0}}, caOut};
	assign portBData    = abOut;
	// drive port a only on a selected read, port b whenever selected; a write or a high select leaves the bus free
	assign portADataOe_n = samp2_q[SAMP_SEL_A] || samp2_q[SAMP_DIR_A];
	assign portBDataOe_n = samp2_q[SAMP_SEL_B];

	////////////////////////////////////////////////////////////////////////////
	// flags read high as not-empty/ready and not-full/space in both modes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			portAEmptyOrOutReady <= 1'b0;
			portAFullOrInReady   <= 1'b0;
		end else if (aEdge && modeValid_q) begin
			portAEmptyOrOutReady <= fallThrough_q ? caReady : !caEmpty;
			portAFullOrInReady   <= !abFull;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			portBEmptyOrOutReady <= 1'b0;
		end else if (bEdge && modeValid_q) begin
			portBEmptyOrOutReady <= fallThrough_q ? abReady : !abEmpty;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			portCFullOrInReady <= 1'b0;
		end else if (cEdge && modeValid_q) begin
			portCFullOrInReady <= !caFull;
		end
	end
endmodule
